// [verilog/fdm_pkg.sv]
`default_nettype none
package fdm_pkg;

  // Which of the three special function registers an access touches.
  typedef enum logic [1:0] {
    FDM_SEL_NONE,
    FDM_SEL_DATA,
    FDM_SEL_ADDR,
    FDM_SEL_CTRL
  } fdm_sel_e;

  // One register access from the core, qualified by the retire strobe.
  typedef struct packed {
    logic ret;
    logic wr;
    logic bset;
    fdm_sel_e sel;
    logic [7:0] data;
  } fdm_sfr_req_s;

  // Array geometry.
  localparam int FDM_ADDR_W = 6;
  localparam int FDM_DEPTH = 64;
  localparam int FDM_CELL_W = 12;
  localparam int FDM_ROW_LSB = 3;
  localparam int FDM_ROW_MSB = 5;
  localparam int FDM_ROW_LEN = 8;
  localparam logic [3:0] FDM_UPPER_ONES = 4'hF;
  localparam logic [11:0] FDM_ERASED = 12'hFFF;

  // Control register field positions.
  localparam int FDM_CTL_RD = 0;
  localparam int FDM_CTL_START = 1;
  localparam int FDM_CTL_UNLOCK = 2;
  localparam int FDM_CTL_ABORT = 3;
  localparam int FDM_CTL_ERASE = 4;

  // Reset values of the register contents.
  localparam logic [4:0] FDM_CTL_RESET = 5'h00;
  localparam logic [7:0] FDM_DATA_RESET = 8'h00;
  localparam logic [5:0] FDM_ADDR_RESET = 6'h00;

  // Cell programming and row erase times, rounded up to whole clocks.
  localparam int FDM_CLK_PERIOD_PS = 4000;
  localparam int FDM_ERASE_TIME_NS = 2000;
  localparam int FDM_WRITE_TIME_NS = 2000;
  localparam int FDM_ERASE_CYC =
    (FDM_ERASE_TIME_NS * 1000 + FDM_CLK_PERIOD_PS - 1) / FDM_CLK_PERIOD_PS;
  localparam int FDM_WRITE_CYC =
    (FDM_WRITE_TIME_NS * 1000 + FDM_CLK_PERIOD_PS - 1) / FDM_CLK_PERIOD_PS;
  localparam int FDM_CNT_W = 12;

endpackage
`default_nettype wire

// [verilog/fdm_rst_sync.sv]
`default_nettype none
module fdm_rst_sync (
  // Clock and raw reset.
  input wire logic clk_i,
  input wire logic arst_b_i,
  // Released reset.
  output logic srst_b_o
);

  logic meta_r;

  // Assert at once, release only after two clean edges to avoid metastable release.
  always_ff @(posedge clk_i or negedge arst_b_i) begin
    if (!arst_b_i) begin
      meta_r <= 1'b0;
      srst_b_o <= 1'b0;
    end else begin
      meta_r <= 1'b1;
      srst_b_o <= meta_r;
    end
  end

endmodule
`default_nettype wire

// [verilog/fdm_array.sv]
`default_nettype none
module fdm_array
  import fdm_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Read port.
  input wire logic [FDM_ADDR_W-1:0] rd_addr_i,
  output logic [7:0] rd_data_o,
  // Program and erase request.
  input wire logic op_start_i,
  input wire logic op_erase_i,
  input wire logic [FDM_ADDR_W-1:0] op_addr_i,
  input wire logic [7:0] op_data_i,
  output logic done_o
);

  logic [FDM_CELL_W-1:0] mem [FDM_DEPTH];
  logic busy_r;
  logic erase_r;
  logic [FDM_ADDR_W-1:0] addr_r;
  logic [7:0] latch_r;
  logic [FDM_CNT_W-1:0] cnt_r;
  logic commit;

  // Only the low byte of a cell is visible to the core.
  assign rd_data_o = mem[rd_addr_i][7:0];
  assign commit = busy_r && (cnt_r == '0);

  // Operation timer; a reset mid-cycle simply drops the operation.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_r <= 1'b0;
      erase_r <= 1'b0;
      addr_r <= '0;
      latch_r <= '0;
      cnt_r <= '0;
      done_o <= 1'b0;
    end else begin
      done_o <= commit;
      if (op_start_i && !busy_r) begin
        busy_r <= 1'b1;
        erase_r <= op_erase_i;
        addr_r <= op_addr_i;
        latch_r <= op_data_i;
        cnt_r <= op_erase_i ? FDM_CNT_W'(FDM_ERASE_CYC - 1) : FDM_CNT_W'(FDM_WRITE_CYC - 1);
      end else if (commit) begin
        busy_r <= 1'b0;
      end else if (busy_r) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  // Cells are nonvolatile, so the storage itself has no reset.
  always_ff @(posedge clk_i) begin
    if (commit) begin
      if (erase_r) begin
        for (int i = 0; i < FDM_ROW_LEN; i++) begin
          mem[{addr_r[FDM_ROW_MSB:FDM_ROW_LSB], 3'(i)}] <= FDM_ERASED;
        end
      end else begin
        // upper nibble forced high
        // A program can only pull erased bits low, like a real cell.
        mem[addr_r] <= {FDM_UPPER_ONES, mem[addr_r][7:0] & latch_r};
      end
    end
  end

endmodule
`default_nettype wire

// [verilog/fdm_ctrl.sv]
`default_nettype none
module fdm_ctrl
  import fdm_pkg::*;
(
  // Clock and resets.
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic por_b_i,
  // Register access from the core.
  input wire fdm_sfr_req_s req_i,
  // Register contents as seen by the core.
  output logic [7:0] data_buf_o,
  output logic [7:0] addr_ptr_o,
  output logic [7:0] control_o,
  // Core stall during erase and write.
  output logic stall_o
);

  typedef enum logic [1:0] {
    FDM_ST_IDLE,
    FDM_ST_ERASE,
    FDM_ST_WRITE
  } fdm_state_e;

  logic rst_b;
  logic por_b;
  fdm_state_e state_r;
  logic [7:0] buf_r;
  logic [FDM_ADDR_W-1:0] addr_r;
  logic erase_r;
  logic abort_r;
  logic unlock_r;
  logic start_r;
  logic rd_r;
  logic unlock_armed_r;
  logic erase_armed_r;
  logic progress_r;
  logic released_r;
  logic [7:0] arr_rd;
  logic arr_done;
  logic ctl_wr;
  logic ctl_bset;
  logic go;
  logic rd_go;

  fdm_rst_sync u_dev_sync (
    .clk_i(sys_clk_i),
    .arst_b_i(rst_b_i),
    .srst_b_o(rst_b)
  );

  fdm_rst_sync u_por_sync (
    .clk_i(sys_clk_i),
    .arst_b_i(por_b_i),
    .srst_b_o(por_b)
  );

  fdm_array u_array (
    .clk_i(sys_clk_i),
    .rst_b_i(rst_b),
    .rd_addr_i(addr_r),
    .rd_data_o(arr_rd),
    .op_start_i(go),
    .op_erase_i(erase_r),
    .op_addr_i(addr_r),
    .op_data_i(buf_r),
    .done_o(arr_done)
  );

  // Accesses count only on a retiring instruction and never while stalled.
  // no protection gating
  assign ctl_wr = req_i.ret && req_i.wr && (req_i.sel == FDM_SEL_CTRL) &&
                  (state_r == FDM_ST_IDLE);
  assign ctl_bset = ctl_wr && req_i.bset;
  assign go = ctl_bset && req_i.data[FDM_CTL_START] && unlock_r;
  assign rd_go = ctl_bset && req_i.data[FDM_CTL_RD];

  assign control_o = {3'h0, erase_r, abort_r, unlock_r, start_r, rd_r};
  assign addr_ptr_o = {2'h0, addr_r};
  assign data_buf_o = buf_r;

  // Operation sequencing and the core stall.
  always_ff @(posedge sys_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= FDM_ST_IDLE;
      stall_o <= 1'b0;
    end else begin
      unique case (state_r)
        FDM_ST_IDLE: begin
          if (go) begin
            state_r <= erase_r ? FDM_ST_ERASE : FDM_ST_WRITE;
            stall_o <= 1'b1;
          end
        end
        FDM_ST_ERASE, FDM_ST_WRITE: begin
          if (arr_done) begin
            state_r <= FDM_ST_IDLE;
            stall_o <= 1'b0;
          end
        end
      endcase
    end
  end

  // Data buffer: written by the core or loaded by a read, never by a write cycle.
  always_ff @(posedge sys_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      buf_r <= FDM_DATA_RESET;
    end else if (rd_go) begin
      buf_r <= arr_rd;
    end else if (req_i.ret && req_i.wr && req_i.sel == FDM_SEL_DATA &&
                 state_r == FDM_ST_IDLE) begin
      buf_r <= req_i.data;
    end
  end

  // Address pointer.
  always_ff @(posedge sys_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      addr_r <= FDM_ADDR_RESET;
    end else if (req_i.ret && req_i.wr && req_i.sel == FDM_SEL_ADDR &&
                 state_r == FDM_ST_IDLE) begin
      addr_r <= req_i.data[FDM_ADDR_W-1:0];
    end
  end

  // Read-start shows for one clock; the data is already in the buffer.
  always_ff @(posedge sys_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      rd_r <= FDM_CTL_RESET[FDM_CTL_RD];
    end else begin
      rd_r <= rd_go;
    end
  end

  // Program-start stays high for the whole cycle.
  always_ff @(posedge sys_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      start_r <= FDM_CTL_RESET[FDM_CTL_START];
    end else if (go) begin
      start_r <= 1'b1;
    end else if (arr_done) begin
      start_r <= 1'b0;
    end
  end

  // The timed windows below count retiring instructions, not clocks.
  // A core that stretches an instruction over several clocks must keep
  // the retire strobe low until the last of them, or a window closes early.
  // Only bit-set writes may open the unlock window, so a stray byte write
  // that happens to carry the unlock bit can never arm a cycle.
  // The unlock bit is also consumed by the cycle that it started, so a
  // later start always needs a fresh unlock sequence of its own.

  // Arms the unlock window on the bit-set that raises write-unlock.
  always_ff @(posedge sys_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      unlock_armed_r <= 1'b0;
    end else if (ctl_bset && req_i.data[FDM_CTL_UNLOCK] && !unlock_r) begin
      unlock_armed_r <= 1'b1;
    end else if (req_i.ret) begin
      // Whatever retires next closes the window, start or not.
      unlock_armed_r <= 1'b0;
    end
  end

  // Write-unlock: only a bit-set raises it, any write may drop it.
  always_ff @(posedge sys_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      unlock_r <= FDM_CTL_RESET[FDM_CTL_UNLOCK];
    end else if (ctl_bset && req_i.data[FDM_CTL_UNLOCK] && !unlock_r) begin
      unlock_r <= 1'b1;
    end else if (req_i.ret && unlock_armed_r) begin
      if (!go) begin
        unlock_r <= 1'b0;
      end
    end else if (arr_done) begin
      // The finished cycle used the unlock up; a leftover would defeat the sequence.
      unlock_r <= 1'b0;
    end else if (ctl_wr && !req_i.bset) begin
      unlock_r <= unlock_r & req_i.data[FDM_CTL_UNLOCK];
    end
  end

  // Arms the erase window on the write that raises row-erase select.
  // Unlike unlock, any kind of write may raise it, so the window is
  // the only guard against a stray erase request.
  always_ff @(posedge sys_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      erase_armed_r <= 1'b0;
    end else if (ctl_wr && req_i.data[FDM_CTL_ERASE] && !erase_r) begin
      erase_armed_r <= 1'b1;
    end else if (req_i.ret) begin
      // The very next retire must be the bit-set of unlock.
      erase_armed_r <= 1'b0;
    end
  end

  // Row-erase select: any write may set it, but unlock must follow at once.
  always_ff @(posedge sys_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      erase_r <= FDM_CTL_RESET[FDM_CTL_ERASE];
    end else if (ctl_wr && req_i.data[FDM_CTL_ERASE] && !erase_r) begin
      erase_r <= 1'b1;
    end else if (req_i.ret && erase_armed_r) begin
      if (!(ctl_bset && req_i.data[FDM_CTL_UNLOCK])) begin
        erase_r <= 1'b0;
      end
    end else if (state_r == FDM_ST_ERASE && arr_done) begin
      erase_r <= 1'b0;
    end else if (ctl_wr) begin
      erase_r <= req_i.data[FDM_CTL_ERASE];
    end
  end

  // First clock after the device reset releases.
  always_ff @(posedge sys_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      released_r <= 1'b0;
    end else begin
      released_r <= 1'b1;
    end
  end

  // Marks a cycle in flight; kept until the first clock of a device reset so an abort can be seen.
  always_ff @(posedge sys_clk_i or negedge por_b) begin
    if (!por_b) begin
      progress_r <= 1'b0;
    end else if (!released_r) begin
      progress_r <= 1'b0;
    end else if (go) begin
      progress_r <= 1'b1;
    end else if (arr_done) begin
      progress_r <= 1'b0;
    end
  end

  // Abort flag lives on the power-on reset; detection beats any clear.
  always_ff @(posedge sys_clk_i or negedge por_b) begin
    if (!por_b) begin
      abort_r <= FDM_CTL_RESET[FDM_CTL_ABORT];
    end else if (!released_r && progress_r) begin
      abort_r <= 1'b1;
    end else if (arr_done) begin
      abort_r <= 1'b0;
    end else if (ctl_wr) begin
      abort_r <= req_i.data[FDM_CTL_ABORT];
    end
  end

endmodule
`default_nettype wire

// [sim/fdm_ctrl_chk.sv]
`default_nettype none
module fdm_ctrl_chk
  import fdm_pkg::*;
(
  // Watched ports of the controller.
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic por_b_i,
  input wire fdm_sfr_req_s req_i,
  input wire logic [7:0] data_buf_o,
  input wire logic [7:0] addr_ptr_o,
  input wire logic [7:0] control_o,
  input wire logic stall_o
);
  localparam int CYC_LO = 495;
  localparam int CYC_HI = 510;

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  // A bit-set write to the control register that the block will take.
  logic ctl_bset;
  assign ctl_bset = req_i.ret && req_i.wr && req_i.bset && req_i.sel == FDM_SEL_CTRL && !stall_o;

  // Counts stalled clocks, so a cycle cut short or stretched shows at its end.
  int run_cnt;
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      run_cnt <= 0;
    end else begin
      run_cnt <= stall_o ? run_cnt + 1 : 0;
    end
  end

  a_ctrl_upper_zero: assert property (control_o[7:5] == 3'h0)
    else $error("control upper bits set");
  a_addr_upper_zero: assert property (addr_ptr_o[7:6] == 2'h0)
    else $error("address upper bits set");
  a_start_runs: assert property (ctl_bset && req_i.data[1] && control_o[2] |=> stall_o && control_o[1])
    else $error("unlocked start did not stall");
  a_cycle_length: assert property ($fell(stall_o) |-> run_cnt >= CYC_LO && run_cnt <= CYC_HI)
    else $error("cycle length wrong");
  a_cycle_ends: assert property ($rose(stall_o) |-> ##[1:CYC_HI] !stall_o)
    else $error("stall never ended");
  a_end_clears: assert property ($fell(stall_o) |-> !control_o[1] && !control_o[4])
    else $error("start or erase bit left set");
  a_unlock_drop: assert property (control_o[2] && !stall_o && req_i.ret && !ctl_bset |=> !control_o[2])
    else $error("unlock kept past next instruction");
  a_erase_drop: assert property (control_o[4] && !control_o[2] && !stall_o && req_i.ret && !ctl_bset
    |=> !control_o[4])
    else $error("erase select kept without unlock");
  a_locked_no_run: assert property (ctl_bset && req_i.data[1] && !control_o[2] |=> !stall_o && !control_o[1])
    else $error("start ran while locked");
  a_read_pulse: assert property (ctl_bset && req_i.data[0] |=> control_o[0] ##1 !control_o[0])
    else $error("read start not one clock");
  a_buf_held: assert property (stall_o |=> $stable(data_buf_o))
    else $error("buffer changed during cycle");
endmodule
`default_nettype wire

// [sim/fdm_core_model.sv]
`default_nettype none
module fdm_core_model
  import fdm_pkg::*;
(
  // Clock and stall from the block.
  input wire logic clk_i,
  input wire logic stall_i,
  // Register accesses to the block.
  output fdm_sfr_req_s req_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial req_o = '0;

  // One retired register write; a stalled core issues nothing until it resumes.
  task automatic acc(input fdm_sel_e sel, input logic bset, input logic [7:0] d);
    @(negedge clk_i);
    while (stall_i) @(negedge clk_i);
    req_o <= '{ret: 1'b1, wr: 1'b1, bset: bset, sel: sel, data: d};
  endtask

  // No instruction retires; the data lines toggle so stale values never look valid.
  task automatic idle();
    @(negedge clk_i);
    req_o.ret <= 1'b0;
    req_o.data <= ~req_o.data;
  endtask

  task automatic start_op(input logic erase);
    if (erase) acc(FDM_SEL_CTRL, 1'b0, 8'h10);
    acc(FDM_SEL_CTRL, 1'b1, erase ? 8'h14 : 8'h04);
    acc(FDM_SEL_CTRL, 1'b1, erase ? 8'h16 : 8'h06);
    idle();
  endtask

  task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
    acc(FDM_SEL_ADDR, 1'b0, a);
    acc(FDM_SEL_DATA, 1'b0, d);
    start_op(1'b0);
  endtask

  task automatic erase_row(input logic [7:0] a);
    acc(FDM_SEL_ADDR, 1'b0, a);
    start_op(1'b1);
  endtask

  task automatic read_byte(input logic [7:0] a);
    acc(FDM_SEL_ADDR, 1'b0, a);
    acc(FDM_SEL_CTRL, 1'b1, 8'h01);
    idle();
  endtask
endmodule
`default_nettype wire

// [sim/flash_data_memory_control_test.sv]
`default_nettype none
module flash_data_memory_control_test
  import fdm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic por_b_i = 1'b0;
  fdm_sfr_req_s req;
  logic [7:0] data_buf;
  logic [7:0] addr_ptr;
  logic [7:0] control;
  logic stall;
  int errors = 0;
  int num_checks = 0;
  logic [7:0] mem [FDM_DEPTH];
  logic [5:0] a;

  initial forever #2 sys_clk_i = ~sys_clk_i;

  fdm_ctrl fdm_ctrl_inst (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .por_b_i(por_b_i),
    .req_i(req), .data_buf_o(data_buf), .addr_ptr_o(addr_ptr), .control_o(control),
    .stall_o(stall));
  fdm_core_model fdm_core_model_inst (.clk_i(sys_clk_i), .stall_i(stall), .req_o(req));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // An erase or write must stall at once and end well inside the bound.
  task automatic finish_op();
    int n;
    chk({7'h0, stall}, 8'h01);
    n = 0;
    while (stall === 1'b1 && n < 1000) begin
      @(negedge sys_clk_i);
      n++;
    end
    chk({7'h0, stall}, 8'h00);
    chk(control, 8'h00);
  endtask

  task automatic do_erase(input logic [5:0] ra);
    fdm_core_model_inst.erase_row({2'h0, ra});
    finish_op();
    for (int i = 0; i < FDM_ROW_LEN; i++) mem[{ra[5:3], 3'(i)}] = 8'hFF;
  endtask

  task automatic do_write(input logic [5:0] wa, input logic [7:0] wd);
    fdm_core_model_inst.write_byte({2'h0, wa}, wd);
    finish_op();
    chk(data_buf, wd);
    mem[wa] = mem[wa] & wd;
  endtask

  task automatic do_read(input logic [5:0] ra);
    fdm_core_model_inst.read_byte({2'h0, ra});
    chk(data_buf, mem[ra]);
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Main sequence; every write is preceded by an erase of its row.
  initial begin
    void'($urandom(82));
    repeat (4) @(negedge sys_clk_i);
    rst_b_i = 1'b1;
    por_b_i = 1'b1;
    repeat (3) @(negedge sys_clk_i);
    chk(control, 8'h00);
    chk(addr_ptr, 8'h00);
    fdm_core_model_inst.acc(FDM_SEL_ADDR, 1'b0, 8'hFF);
    fdm_core_model_inst.acc(FDM_SEL_CTRL, 1'b1, 8'hE0);
    fdm_core_model_inst.idle();
    chk(addr_ptr, 8'h3F);
    chk(control, 8'h00);
    $display("test registers done");
    for (int k = 0; k < 4; k++) begin
      a = 6'($urandom);
      do_erase(a);
      for (int i = 0; i < FDM_ROW_LEN; i++) do_read({a[5:3], 3'(i)});
      do_write(a, 8'($urandom));
      do_read(a);
      do_write(a, 8'($urandom));
      do_read(a);
    end
    $display("test erase write read done");
    fdm_core_model_inst.acc(FDM_SEL_CTRL, 1'b1, 8'h04);
    fdm_core_model_inst.acc(FDM_SEL_NONE, 1'b0, 8'h00);
    fdm_core_model_inst.acc(FDM_SEL_CTRL, 1'b1, 8'h02);
    fdm_core_model_inst.acc(FDM_SEL_CTRL, 1'b0, 8'h06);
    fdm_core_model_inst.acc(FDM_SEL_CTRL, 1'b0, 8'h10);
    fdm_core_model_inst.acc(FDM_SEL_NONE, 1'b0, 8'h00);
    fdm_core_model_inst.idle();
    chk({7'h0, stall}, 8'h00);
    chk(control, 8'h00);
    do_read(a);
    $display("test refusals done");
    fdm_core_model_inst.write_byte({2'h0, a}, 8'h00);
    repeat (10) @(negedge sys_clk_i);
    rst_b_i = 1'b0;
    repeat (4) @(negedge sys_clk_i);
    rst_b_i = 1'b1;
    repeat (3) @(negedge sys_clk_i);
    chk(control, 8'h08);
    por_b_i = 1'b0;
    repeat (4) @(negedge sys_clk_i);
    por_b_i = 1'b1;
    repeat (3) @(negedge sys_clk_i);
    chk(control, 8'h00);
    $display("test abort done");
    tally_and_finish();
  end

  // Cuts a hang short well past the expected run of some six thousand two hundred and fifty clocks.
  initial begin
    #100000;
    errors++;
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    tally_and_finish();
  end
endmodule

bind fdm_ctrl fdm_ctrl_chk fdm_ctrl_chk_inst (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
  .por_b_i(por_b_i), .req_i(req_i), .data_buf_o(data_buf_o), .addr_ptr_o(addr_ptr_o),
  .control_o(control_o), .stall_o(stall_o));
`default_nettype wire
